// ==== design/cw_bit_gate.sv ====
`timescale 1ns/100ps
// Purpose : splits the command word into bits, applies remote gating
// Assumes : word is a registered value
// Notes   : stop bits bypass the remote gate on purpose
module cw_bit_gate
  import cw_decode_pkg::*;
(
  // command word
  input  wire logic [cw_decode_pkg::WORD_W-1:0] word,
  // decoded bits
  cw_bits_if.src                                 bits
);

  // ==========================================================
  // field pick
  function automatic logic pick(input logic [WORD_W-1:0] w, input int p);
    pick = w[p];
  endfunction

  logic rem; // remote control enable
  assign rem = pick(word, REMOTE_POS);                         // R17

  // stop bits are never gated so a local stop always works
  assign bits.ramp_stop_bit      = pick(word, RAMP_STOP_POS);  // R17
  assign bits.coast_stop_bit     = pick(word, COAST_STOP_POS); // R17
  assign bits.emergency_stop_bit = pick(word, EMERG_STOP_POS); // R17
  assign bits.run             = rem & pick(word, RUN_POS);
  assign bits.ramp_out_on     = rem & pick(word, RAMP_OUT_POS);
  assign bits.ramp_accel_on   = rem & pick(word, RAMP_HOLD_POS);
  assign bits.ramp_in_on      = rem & pick(word, RAMP_IN_POS);
  assign bits.fault_rst_level = rem & pick(word, FAULT_RST_POS);
  assign bits.remote          = rem;
  assign bits.loc_two         = rem & pick(word, LOC_SEL_POS);
  assign bits.user = word[USER_LO_POS +: USER_W];

endmodule

// ==== design/cw_bits_if.sv ====
`timescale 1ns/100ps
// Purpose : carries the gated command bits from decoder to top
// Assumes : both ends on sys_clk
// Notes   : purely combinational bundle
interface cw_bits_if;
  logic ramp_stop_bit;      // bit 0, always honoured
  logic coast_stop_bit;     // bit 1, always honoured
  logic emergency_stop_bit; // bit 2, always honoured
  logic run;                // bit 3 gated by remote enable
  logic ramp_out_on;        // bit 4 gated
  logic ramp_accel_on;      // bit 5 gated
  logic ramp_in_on;         // bit 6 gated
  logic fault_rst_level;    // bit 7 gated
  logic remote;             // bit 10
  logic loc_two;            // bit 11 gated
  logic [3:0] user;         // bits 12..15

  modport src (output ramp_stop_bit, coast_stop_bit, emergency_stop_bit,
               run, ramp_out_on, ramp_accel_on, ramp_in_on,
               fault_rst_level, remote, loc_two, user);
  modport dst (input ramp_stop_bit, coast_stop_bit, emergency_stop_bit,
               run, ramp_out_on, ramp_accel_on, ramp_in_on,
               fault_rst_level, remote, loc_two, user);
endinterface

// ==== design/cw_decode_pkg.sv ====
// Purpose : shared constants and types for the command word decoder
// Assumes : one 20 MHz clock, synchronous active-low reset
// Notes   : bit positions follow the cyclic 16-bit command word layout
package cw_decode_pkg;

  // ==========================================================
  // word geometry
  localparam int          WORD_W        = 16;   // process data word width
  localparam int          MAX_WORDS     = 12;   // words per direction
  localparam int          WORD_IDX_W    = 4;    // index width for words

  // ==========================================================
  // command word bit positions
  localparam int          RAMP_STOP_POS   = 0;
  localparam int          COAST_STOP_POS  = 1;
  localparam int          EMERG_STOP_POS  = 2;
  localparam int          RUN_POS         = 3;
  localparam int          RAMP_OUT_POS    = 4;
  localparam int          RAMP_HOLD_POS   = 5;
  localparam int          RAMP_IN_POS     = 6;
  localparam int          FAULT_RST_POS   = 7;
  localparam int          REMOTE_POS      = 10;
  localparam int          LOC_SEL_POS     = 11;
  localparam int          USER_LO_POS     = 12;
  localparam int          USER_W          = 4;

  // ==========================================================
  // reset values
  localparam logic [15:0] CMD_RESET       = 16'h0000;
  localparam logic [15:0] STATUS_RESET    = 16'h0040;

  // status word bit positions
  localparam int          ST_ENERGIZE   = 0;
  localparam int          ST_RUN_READY  = 1;
  localparam int          ST_REF_READY  = 2;
  localparam int          ST_TRIPPED    = 3;
  localparam int          ST_COAST_OFF  = 4;
  localparam int          ST_EMERG_OFF  = 5;
  localparam int          ST_INHIBIT    = 6;
  localparam int          ST_AT_SETPT   = 8;
  localparam int          ST_REMOTE     = 9;

  // ==========================================================
  // drive state machine
  typedef enum logic [3:0] {
    inhibited_state             = 4'h0,
    energize_ready_state        = 4'h1,
    run_ready_state             = 4'h2,
    op_enabled_state            = 4'h3,
    ramp_stop_active_state      = 4'h4,
    coast_stop_active_state     = 4'h5,
    emergency_stop_active_state = 4'h6,
    fault_state                 = 4'h7
  } drive_state_t;

endpackage

// ==== design/drive_control_word_decoder.sv ====
`timescale 1ns/100ps
// Purpose : decodes the cyclic fieldbus command word into drive state
//           and ramp generator controls, returns a status word
// Assumes : word_valid marks each new cyclic command word
// Notes   : source-select straps are plain inputs, no register bus

// Overview of operation
// R01: bit0 high advances toward run ready
// R02: bit0 low ramps down, ramp stop state
// R03: leave ramp stop only without other interlocks
// R04: bit1 low coasts, then switch-on inhibited
// R05: bit2 low quick stops, then inhibited
// R06: bit3 high enables operation with run enable
// R07: bit3 low inhibits operation
// R08: bus-sourced run enable follows bit3
// R09: bit4 high lets ramp output run
// R10: bit4 low forces ramp output zero
// R11: bit5 high enables ramp accelerator
// R12: bit5 low holds ramp output
// R13: bit6 low zeroes ramp input
// R14: bit6 acts only if bus selected
// R15: bit7 rising edge resets active fault
// R16: bit7 acts only if bus selected
// R17: bit10 low ignores word except stops; user bits 12..15 still pass through ungated
// R18: bit11 selects external location one/two
// R19: cyclic word in, status word out
// R20: sixteen-bit words, up to twelve each
// R21: reset to inhibited, previous bit7 low
module drive_control_word_decoder
  import cw_decode_pkg::*;
(
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              nrst,
  // cyclic command word from adapter
  input  wire logic [cw_decode_pkg::WORD_W-1:0]  fieldbus_command_word,
  input  wire logic                              word_valid,
  input  wire logic [cw_decode_pkg::WORD_IDX_W-1:0] word_index,
  // source selection straps
  input  wire logic                              run_en_from_bus,
  input  wire logic                              run_en_ext,
  input  wire logic                              ramp_in_from_bus,
  input  wire logic                              reset_from_bus,
  input  wire logic                              loc_from_bus,
  // drive side feedback
  input  wire logic                              fault_in,
  input  wire logic                              stop_done,
  input  wire logic                              at_setpoint,
  // drive controls
  output logic [3:0]                             drive_state,
  output logic                                   run_enable,
  output logic                                   ramp_out_zero,
  output logic                                   ramp_hold,
  output logic                                   ramp_in_zero,
  output logic                                   coast_cmd,
  output logic                                   quick_stop_cmd,
  output logic                                   fault_reset,
  output logic                                   loc_two_sel,
  output logic [3:0]                             user_bits,
  // status word back to master
  output logic [cw_decode_pkg::WORD_W-1:0]       status_word
);
  import cw_decode_pkg::*;

  // ==========================================================
  // command word capture
  logic [WORD_W-1:0] cmd_ff;     // latest word, index zero only
  cw_bits_if         bits ();    // decoded, gated fields

  // only word zero carries the command; others are references etc.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cmd_ff <= CMD_RESET;
    end else if (word_valid && word_index == '0) begin // R19 R20
      cmd_ff <= fieldbus_command_word;
    end
  end

  cw_bit_gate u_gate (
    .word (cmd_ff),
    .bits (bits)
  );

  // ==========================================================
  // fault reset edge
  logic         rst_prev_ff; // previous bit 7 level
  logic         rst_edge;    // rising edge of bit 7
  logic         rst_take;    // edge accepted while faulted
  logic         fault_ff;    // latched fault indication
  drive_state_t state_ff;    // current state
  drive_state_t nxt_state;   // next state

  // a level held high gives one edge only, so a stuck bit cannot
  // keep clearing faults
  assign rst_edge = bits.fault_rst_level & ~rst_prev_ff &
                    reset_from_bus;                            // R16

  // the edge counts only in the fault state and only with no new
  // fault pending: a fresh fault outranks the reset, and a fault
  // still on its way into the fault state cannot be cleared early
  assign rst_take = rst_edge & (state_ff == fault_state) & ~fault_in; // R15

  // previous level starts low, so a bit held high gives one edge once a word is taken after reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rst_prev_ff <= 1'b0;                                     // R21
    end else begin
      rst_prev_ff <= bits.fault_rst_level;
    end
  end

  // new fault wins over a reset in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fault_ff <= 1'b0;
    end else if (fault_in) begin
      fault_ff <= 1'b1;
    end else if (rst_take) begin                               // R15 R16
      fault_ff <= 1'b0;
    end
  end

  // ==========================================================
  // run enable source
  logic run_en;  // effective run enable
  assign run_en = run_en_from_bus ? bits.run : run_en_ext;     // R08

  // ==========================================================
  // drive state machine
  // state_ff and nxt_state are declared with the fault logic,
  // which has to look at the current state as well
  // a latched fault overrides every other request

  always_comb begin
    nxt_state = state_ff;
    if (fault_ff && state_ff != fault_state) begin
      nxt_state = fault_state;
    end else begin
      case (state_ff)
        fault_state: begin
          // leave only on an accepted reset, never with a fault pending
          if (rst_take) nxt_state = inhibited_state;          // R15
        end
        coast_stop_active_state: begin
          if (stop_done) nxt_state = inhibited_state;         // R04
        end
        emergency_stop_active_state: begin
          if (stop_done) nxt_state = inhibited_state;         // R05
        end
        ramp_stop_active_state: begin
          if (!bits.coast_stop_bit)
            nxt_state = coast_stop_active_state;
          else if (!bits.emergency_stop_bit)
            nxt_state = emergency_stop_active_state;
          else if (stop_done)
            nxt_state = energize_ready_state;                 // R03
        end
        default: begin
          // coast stop outranks quick stop, which outranks ramp stop
          if (!bits.coast_stop_bit) begin
            nxt_state = (state_ff == inhibited_state) ?
                        inhibited_state : coast_stop_active_state; // R04
          end else if (!bits.emergency_stop_bit) begin
            nxt_state = (state_ff == inhibited_state) ?
                        inhibited_state :
                        emergency_stop_active_state;           // R05
          end else begin
            case (state_ff)
              inhibited_state: begin
                // leaving inhibit needs bit 0 low first
                if (!bits.ramp_stop_bit)
                  nxt_state = energize_ready_state;
              end
              energize_ready_state: begin
                if (bits.ramp_stop_bit)
                  nxt_state = run_ready_state;                 // R01
              end
              run_ready_state: begin
                if (!bits.ramp_stop_bit)
                  nxt_state = energize_ready_state;
                else if (bits.run && run_en)
                  nxt_state = op_enabled_state;                // R06
              end
              op_enabled_state: begin
                if (!bits.ramp_stop_bit)
                  nxt_state = ramp_stop_active_state;          // R02
                else if (!bits.run || !run_en)
                  nxt_state = run_ready_state;                 // R07
              end
              default: nxt_state = inhibited_state;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_ff <= inhibited_state;                             // R21
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // registered drive controls
  logic op_on; // operation enabled next cycle
  assign op_on = (nxt_state == op_enabled_state);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      drive_state    <= inhibited_state;
      run_enable     <= 1'b0;
      ramp_out_zero  <= 1'b1;
      ramp_hold      <= 1'b0;
      ramp_in_zero   <= 1'b1;
      coast_cmd      <= 1'b0;
      quick_stop_cmd <= 1'b0;
      fault_reset    <= 1'b0;
      loc_two_sel    <= 1'b0;
      user_bits      <= 4'h0;
    end else begin
      drive_state    <= nxt_state;
      run_enable     <= run_en;                                // R08
      // ramp forcing matters only while operating
      ramp_out_zero  <= !(op_on && bits.ramp_out_on);          // R09 R10
      ramp_hold      <= op_on && !bits.ramp_accel_on;          // R11 R12
      ramp_in_zero   <= ramp_in_from_bus ?
                        !(op_on && bits.ramp_in_on) : 1'b0;    // R13 R14
      coast_cmd      <= (nxt_state == coast_stop_active_state);
      quick_stop_cmd <= (nxt_state == emergency_stop_active_state);
      // one-cycle pulse, in the same edge that leaves the fault state
      fault_reset    <= rst_take;                              // R15
      if (loc_from_bus && bits.remote) begin
        loc_two_sel  <= bits.loc_two;                          // R18
      end
      user_bits      <= bits.user;
    end
  end

  // ==========================================================
  // status word
  logic [WORD_W-1:0] nxt_status; // assembled status

  always_comb begin
    nxt_status = '0;
    nxt_status[ST_ENERGIZE]  = (nxt_state == energize_ready_state) ||
                               (nxt_state == run_ready_state) ||
                               op_on;
    nxt_status[ST_RUN_READY] = (nxt_state == run_ready_state) || op_on;
    nxt_status[ST_REF_READY] = op_on;
    nxt_status[ST_TRIPPED]   = (nxt_state == fault_state);
    nxt_status[ST_COAST_OFF] = (nxt_state != coast_stop_active_state);
    nxt_status[ST_EMERG_OFF] = (nxt_state != emergency_stop_active_state);
    nxt_status[ST_INHIBIT]   = (nxt_state == inhibited_state);
    nxt_status[ST_AT_SETPT]  = op_on && at_setpoint;
    nxt_status[ST_REMOTE]    = bits.remote;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      status_word <= STATUS_RESET;
    end else begin
      status_word <= nxt_status;                               // R19
    end
  end

endmodule

// ==== tb/drive_control_word_decoder_props.sv ====
// Purpose : temporal checks on the decoder's ports
// Assumes : one clock, synchronous active-low reset
// Notes   : outputs are registered, a taken word shows two edges later
`timescale 1ns/100ps
module drive_control_word_decoder_props
  import cw_decode_pkg::*;
(
  // clock and reset
  input wire logic                             sys_clk,
  input wire logic                             nrst,
  // command word side
  input wire logic [cw_decode_pkg::WORD_W-1:0] fieldbus_command_word,
  input wire logic                             word_valid,
  input wire logic [cw_decode_pkg::WORD_IDX_W-1:0] word_index,
  // straps and feedback
  input wire logic                             run_en_from_bus,
  input wire logic                             run_en_ext,
  input wire logic                             ramp_in_from_bus,
  input wire logic                             reset_from_bus,
  input wire logic                             fault_in,
  // drive controls
  input wire logic [3:0]                       drive_state,
  input wire logic                             run_enable,
  input wire logic                             ramp_out_zero,
  input wire logic                             ramp_hold,
  input wire logic                             ramp_in_zero,
  input wire logic                             coast_cmd,
  input wire logic                             quick_stop_cmd,
  input wire logic                             fault_reset,
  input wire logic [3:0]                       user_bits,
  input wire logic [cw_decode_pkg::WORD_W-1:0] status_word
);
  // ==========================================================
  // all checks share one clock and the reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // a fault request is latched, then the state follows one edge later;
  // only an accepted reset in that same edge may take it out again
  fault_trip_a: assert property (fault_in |-> ##2
    (drive_state == 4'h7 || fault_reset))
    else $error("fault request did not trip the drive");
  coast_flag_a: assert property (coast_cmd == (drive_state == 4'h5))
    else $error("coast command disagrees with state");
  quick_flag_a: assert property (quick_stop_cmd == (drive_state == 4'h6))
    else $error("quick stop command disagrees with state");
  ramp_zero_a: assert property (drive_state != 4'h3 |-> ramp_out_zero)
    else $error("ramp output released outside operation");
  hold_op_a: assert property (ramp_hold |-> drive_state == 4'h3)
    else $error("ramp hold outside operation");
  ramp_in_a: assert property (!ramp_in_from_bus |=> !ramp_in_zero)
    else $error("ramp input zeroed without bus source");
  // the reset pulse is one cycle and leaves the fault state
  reset_pulse_a: assert property (fault_reset |->
    ($past(drive_state) == 4'h7 && drive_state == 4'h0) ##1 !fault_reset)
    else $error("fault reset pulse malformed");
  reset_strap_a: assert property (!reset_from_bus |=> !fault_reset)
    else $error("fault reset without bus source");
  run_strap_a: assert property (!run_en_from_bus |=>
    run_enable == $past(run_en_ext))
    else $error("run enable not following external source");
  op_run_a: assert property (drive_state == 4'h3 |-> run_enable)
    else $error("operation without run enable");
  // a word with remote off may only stop things
  remote_gate_a: assert property (word_valid && word_index == 4'h0 &&
    !fieldbus_command_word[10] |-> ##2 ramp_out_zero && !status_word[9])
    else $error("word acted upon with remote disabled");
  user_pass_a: assert property (word_valid && word_index == 4'h0 |->
    ##2 user_bits == $past(fieldbus_command_word[15:12], 2))
    else $error("user bits not passed through");
  inhibit_flag_a: assert property (status_word[6] == (drive_state == 4'h0))
    else $error("inhibit status disagrees with state");

  // main scenarios reached
  cover property (drive_state == 4'h3);
  cover property (fault_reset);
  cover property (coast_cmd);
  cover property (quick_stop_cmd);
endmodule

bind drive_control_word_decoder drive_control_word_decoder_props u_props (
  .sys_clk, .nrst, .fieldbus_command_word, .word_valid, .word_index,
  .run_en_from_bus, .run_en_ext, .ramp_in_from_bus, .reset_from_bus,
  .fault_in, .drive_state, .run_enable, .ramp_out_zero, .ramp_hold,
  .ramp_in_zero, .coast_cmd, .quick_stop_cmd, .fault_reset, .user_bits,
  .status_word);

// ==== tb/drive_control_word_decoder_tb.sv ====
// Purpose : self-checking bench for the command word decoder
// Assumes : master model feeds words, a bench model predicts outputs
// Notes   : every output compared on each falling edge while out of reset
`timescale 1ns/100ps
module drive_control_word_decoder_tb;
  import cw_decode_pkg::*;
  // ==========================================================
  // signals
  logic        sys_clk, nrst, slow, word_valid, fault_in, stop_done;
  logic        run_en_from_bus, run_en_ext, ramp_in_from_bus;
  logic        reset_from_bus, loc_from_bus, at_setpoint, run_enable;
  logic        ramp_out_zero, ramp_hold, ramp_in_zero, coast_cmd;
  logic        quick_stop_cmd, fault_reset, loc_two_sel;
  logic [3:0]  word_index, drive_state, user_bits;
  logic [15:0] cmd, fieldbus_command_word, status_word, rnd;
  // bench model state and predictions
  logic [15:0] m_cmd, e_stat;
  logic [3:0]  m_st, e_usr;
  logic        m_prev, m_flt, e_run, e_roz, e_hold, e_riz, e_frst, e_loc;
  int          mismatches, n_compared, cycles;

  drive_control_word_decoder dut (.sys_clk, .nrst, .fieldbus_command_word,
    .word_valid, .word_index, .run_en_from_bus, .run_en_ext,
    .ramp_in_from_bus, .reset_from_bus, .loc_from_bus, .fault_in,
    .stop_done, .at_setpoint, .drive_state, .run_enable, .ramp_out_zero,
    .ramp_hold, .ramp_in_zero, .coast_cmd, .quick_stop_cmd, .fault_reset,
    .loc_two_sel, .user_bits, .status_word);
  fieldbus_master_model master (.sys_clk, .cmd, .slow,
    .word(fieldbus_command_word), .valid(word_valid), .idx(word_index));

  // 50 ns clock, cycle count guards against a hang
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end

  // ==========================================================
  // reference model, reasoned from the bit table
  always @(posedge sys_clk) begin : model
    logic       g, ed, run;
    logic [3:0] s;
    g   = m_cmd[10];
    run = run_en_from_bus ? (g & m_cmd[3]) : run_en_ext;
    ed  = g & m_cmd[7] & ~m_prev & reset_from_bus;
    s   = m_st;
    // a fault is latched first and trips the state one edge later
    if (m_flt && m_st != 4'h7) s = 4'h7;
    else if (m_st == 4'h7) s = (ed && !fault_in) ? 4'h0 : 4'h7;
    else if (m_st == 4'h5 || m_st == 4'h6) s = stop_done ? 4'h0 : m_st;
    else if (m_st == 4'h0) s = (!m_cmd[0] && m_cmd[1] && m_cmd[2]);
    else if (!m_cmd[1]) s = 4'h5;
    else if (!m_cmd[2]) s = 4'h6;
    else if (m_st == 4'h4) s = stop_done ? 4'h1 : 4'h4;
    else if (!m_cmd[0]) s = (m_st == 4'h3) ? 4'h4 : 4'h1;
    else if (m_st == 4'h1) s = 4'h2;
    else s = (g && m_cmd[3] && run) ? 4'h3 : 4'h2;
    e_frst = ed & (m_st == 4'h7) & ~fault_in;
    e_roz  = !(s == 4'h3 && g && m_cmd[4]);
    e_hold = s == 4'h3 && g && !m_cmd[5];
    e_riz  = ramp_in_from_bus && !(s == 4'h3 && g && m_cmd[6]);
    if (loc_from_bus && g) e_loc = m_cmd[11];
    e_stat = {6'h0, g, at_setpoint && s == 4'h3, 1'b0, s == 4'h0,
              s != 4'h6, s != 4'h5, s == 4'h7, s == 4'h3,
              s == 4'h2 || s == 4'h3, s >= 4'h1 && s <= 4'h3};
    e_run  = run;
    e_usr  = m_cmd[15:12];
    m_flt  = fault_in | (m_flt & ~(ed & (m_st == 4'h7)));
    m_prev = g & m_cmd[7];
    m_st   = s;
    if (word_valid && word_index == 4'h0) m_cmd = fieldbus_command_word;
    if (!nrst) begin
      {m_cmd, m_st, e_usr, m_prev, m_flt, e_run, e_hold, e_frst, e_loc} = '0;
      {e_roz, e_riz, e_stat} = {2'b11, 16'h0040};
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  always @(negedge sys_clk) begin
    if (nrst === 1'b1) begin
      check("drive_state", 16'(drive_state), 16'(m_st));
      check("run_enable", 16'(run_enable), 16'(e_run));
      check("ramp_out_zero", 16'(ramp_out_zero), 16'(e_roz));
      check("ramp_hold", 16'(ramp_hold), 16'(e_hold));
      check("ramp_in_zero", 16'(ramp_in_zero), 16'(e_riz));
      check("stop_cmds", 16'({coast_cmd, quick_stop_cmd}),
            16'({m_st == 4'h5, m_st == 4'h6}));
      check("fault_reset", 16'(fault_reset), 16'(e_frst));
      check("loc_two_sel", 16'(loc_two_sel), 16'(e_loc));
      check("user_bits", 16'(user_bits), 16'(e_usr));
      check("status_word", status_word, e_stat);
    end
  end

  // ==========================================================
  // stimulus: send a word, wait for it to settle, check the state
  task automatic go(input logic [15:0] w, input logic sd,
                    input logic [3:0] st);
    cmd       = w;
    stop_done = sd;
    repeat (30) @(posedge sys_clk);
    #1;
    check("settled_state", 16'(drive_state), 16'(st));
  endtask

  // xorshift step for the random traffic, seeded by the caller
  function automatic logic [15:0] xorshift(input logic [15:0] v);
    logic [15:0] x;
    x = v ^ (v << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  logic [23:0] steps [20] = '{
    24'h040601, 24'h040702, 24'h040f03, 24'h047f03, 24'h0c6f03,
    24'h045f03, 24'h040702, 24'h040f03, 24'h000702, 24'h040f03,
    24'h040e04, 24'h040e11, 24'h040f03, 24'h040d05, 24'h040d10,
    24'h040601, 24'h040f03, 24'h040b06, 24'h040b10, 24'h040601};

  initial begin
    {nrst, slow, fault_in, stop_done, run_en_ext, cmd} = '0;
    {run_en_from_bus, ramp_in_from_bus, reset_from_bus} = 3'b111;
    {loc_from_bus, at_setpoint, rnd} = {2'b11, 16'h6ead};
    {mismatches, n_compared, cycles} = '0;
    repeat (4) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    // walk through start-up, ramp bits, stops and remote gating
    foreach (steps[i])
      go(steps[i][23:8], steps[i][4], steps[i][3:0]);
    $display("test directed sequence done");
    fault_in = 1'b1;
    go(16'h0406, 1'b0, 4'h7);
    fault_in       = 1'b0;
    reset_from_bus = 1'b0;
    go(16'h0486, 1'b0, 4'h7);
    go(16'h0406, 1'b0, 4'h7);
    reset_from_bus = 1'b1;
    go(16'h0486, 1'b0, 4'h1);
    // a reset from energize ready must drop the drive back to inhibit
    nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("reset_state", 16'(drive_state), 16'h0000);
    nrst = 1'b1;
    $display("test fault reset done");
    // random words and straps with a stalling master
    slow = 1'b1;
    repeat (300) begin
      rnd = xorshift(rnd);
      cmd = rnd | 16'h0006;
      {run_en_from_bus, run_en_ext, ramp_in_from_bus} = rnd[15:13];
      {reset_from_bus, loc_from_bus, stop_done} = rnd[7:5];
      at_setpoint = rnd[8];
      fault_in    = rnd[4] & rnd[11] & rnd[12];
      repeat (6) @(posedge sys_clk);
      #1;
    end
    $display("test random traffic done");
    conclude();
  end
endmodule

// ==== tb/fieldbus_master_model.sv ====
// Purpose : cyclic fieldbus master sending one process word a cycle
// Assumes : slot 0 carries the command word
// Notes   : stalled cycles scramble the word so stale data never helps
`timescale 1ns/100ps
module fieldbus_master_model
  import cw_decode_pkg::*;
(
  // clock
  input  wire logic                                sys_clk,
  // what to send and pacing
  input  wire logic [cw_decode_pkg::WORD_W-1:0]    cmd,
  input  wire logic                                slow,
  // process data toward the drive
  output logic      [cw_decode_pkg::WORD_W-1:0]    word,
  output logic                                     valid,
  output logic      [cw_decode_pkg::WORD_IDX_W-1:0] idx
);
  // ==========================================================
  // slot sequencer
  logic [WORD_IDX_W-1:0] slot = '0;   // next slot to send
  logic                  gap  = 1'b0; // alternates every cycle, used only when slow

  initial begin
    word  = 16'h0000;
    valid = 1'b0;
    idx   = '0;
  end

  // changes land just after the edge, like a real master
  always @(posedge sys_clk) begin
    #1;
    if (slow && !gap) begin
      valid = 1'b0;   // stall: word line shows junk
      word  = ~word;
    end else begin
      valid = 1'b1;
      idx   = slot;
      word  = (slot == '0) ? cmd : ({slot, 12'h5a3} ^ ~word);
      slot  = (slot == WORD_IDX_W'(MAX_WORDS - 1)) ? '0 : slot + 4'h1;
    end
    gap = ~gap;
  end
endmodule
